//--- rtl/input_crossing_irq_enable.sv
// interrupt edge selection, crossing detection and irq for inputs 0 to 11
//
// Functional notes
// - 24-bit rw register, input n owns bits 2n+1 down to 2n.
// - register at index 25h, resets to zero, all interrupts off.
// - code 0: no interrupt for that input.
// - code 1: interrupt only on rising crossing above threshold.
// - code 2: interrupt only on falling crossing below threshold.
// - code 3: interrupt on any threshold crossing.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module input_crossing_irq_enable #(
    parameter int NUM_INPUTS = crossing_irq_pkg::NUM_INPUTS
) (
    input  wire logic                                clk,
    input  wire logic                                rst_n,
    input  wire crossing_irq_pkg::av_req_s           av_req,
    output logic [crossing_irq_pkg::DATA_W-1:0]      av_readdata,
    output logic                                     av_waitrequest,
    input  wire logic [NUM_INPUTS-1:0]               above_threshold,
    output logic                                     irq_n
);

    ////////////////////////////////////////////////////////////////////////
    // register map, word index on the bus, byte address is four times it
    //   25h  edge selection, two bits per input, read/write, reset zero
    //   28h  crossing status, sticky, write one to clear
    //   29h  crossing mask, a one masks the input, reset all masked
    //   2Ah  last sampled comparator levels, read only
    //   other indexes read zero, writes to them are dropped
    //
    // edge selection fields
    //   input0_irq_edge_sel   bits 1:0
    //   input1_irq_edge_sel   bits 3:2
    //   input2_irq_edge_sel   bits 5:4
    //   input3_irq_edge_sel   bits 7:6
    //   input4_irq_edge_sel   bits 9:8
    //   input5_irq_edge_sel   bits 11:10
    //   input6_irq_edge_sel   bits 13:12
    //   input7_irq_edge_sel   bits 15:14
    //   input8_irq_edge_sel   bits 17:16
    //   input9_irq_edge_sel   bits 19:18
    //   input10_irq_edge_sel  bits 21:20
    //   input11_irq_edge_sel  bits 23:22
    //
    // edge selection codes
    //   0  no interrupt for the input
    //   1  rising crossing of input_level_threshold only
    //   2  falling crossing of input_level_threshold only
    //   3  either crossing
    //
    // ports
    //   above_threshold  comparator result per input, a one is above
    //   irq_n            low while any unmasked status bit is set
    //
    // timing
    //   every access waits one cycle, waitrequest drops in the second
    //   back-to-back requests each wait their own cycle again
    //   a read captures its register in the waiting cycle
    //   read data then stands until the next read
    //   a comparator change sets its status bit on the same edge that samples it
    //   irq_n follows an unmasked status bit one edge later
    //   the first cycle after reset never reports a crossing
    //
    // hazards
    //   a clear and a new event in one cycle keep the bit set
    //   edge selection writes honour byte lanes 0 to 2 only
    //   the mask resets to all masked, so no irq before software opts in

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [crossing_irq_pkg::ENABLE_W-1:0] edge_sel_ff;
    logic [NUM_INPUTS-1:0]                 status_ff;
    logic [NUM_INPUTS-1:0]                 mask_ff;
    logic [NUM_INPUTS-1:0]                 level_ff;
    logic                                  level_valid_ff;
    logic [NUM_INPUTS-1:0]                 crossing_hit;
    logic                                  access;
    logic                                  answer;
    logic                                  wr_take;
    logic                                  rd_launch;
    logic [crossing_irq_pkg::ADDR_W-1:0]   word_idx;
    logic [crossing_irq_pkg::DATA_W-1:0]   nxt_readdata;
    logic [crossing_irq_pkg::ENABLE_W-1:0] nxt_edge_sel;
    logic [NUM_INPUTS-1:0]                 nxt_mask;
    logic [NUM_INPUTS-1:0]                 nxt_status;
    logic [NUM_INPUTS-1:0]                 clear_bits;
    logic [NUM_INPUTS-1:0]                 pending;
    logic                                  nxt_irq_n;
    logic                                  nxt_waitrequest;
    logic                                  hit_edge_sel;
    logic                                  hit_status;
    logic                                  hit_mask;

    // bus handshake sequencer states
    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } bus_state_e;
    bus_state_e                            bus_state_ff;
    bus_state_e                            nxt_bus_state;

    // byte lanes that reach the edge selection register
    localparam int LANE_W     = 8;
    localparam int EDGE_LANES = crossing_irq_pkg::ENABLE_W / LANE_W;

    ////////////////////////////////////////////////////////////////////////
    // bus decode: one wait cycle, request taken when waitrequest is low
    assign access    = av_req.read | av_req.write;
    assign answer    = (bus_state_ff == BUS_ANSWER);
    assign word_idx  = {2'h0, av_req.address[crossing_irq_pkg::ADDR_W-1:2]};
    assign wr_take   = av_req.write & answer;
    assign rd_launch = av_req.read & ~answer; // read data captured here

    // word selects for the writable registers
    assign hit_edge_sel = (word_idx == crossing_irq_pkg::EDGE_SEL_IDX);
    assign hit_status   = (word_idx == crossing_irq_pkg::IRQ_STATUS_IDX);
    assign hit_mask     = (word_idx == crossing_irq_pkg::IRQ_MASK_IDX);

    // idle sees a request, answer drops waitrequest for one cycle
    always_comb begin
        nxt_bus_state   = bus_state_ff;
        nxt_waitrequest = 1'b1;
        case (bus_state_ff)
            BUS_IDLE: begin
                if (access) begin
                    nxt_bus_state   = BUS_ANSWER;
                    nxt_waitrequest = 1'b0;
                end
            end
            BUS_ANSWER: begin
                nxt_bus_state   = BUS_IDLE;
                nxt_waitrequest = 1'b1;
            end
            default: begin
                nxt_bus_state   = BUS_IDLE;
                nxt_waitrequest = 1'b1;
            end
        endcase
    end

    // handshake state, back to idle in reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_ff <= BUS_IDLE;
        end else begin
            bus_state_ff <= nxt_bus_state;
        end
    end

    // waitrequest high in reset, between accesses and in the first cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            av_waitrequest <= 1'b1;
        end else begin
            av_waitrequest <= nxt_waitrequest;
        end
    end

    // read data mux, unmapped reads return zero
    always_comb begin
        nxt_readdata = crossing_irq_pkg::UNMAPPED_DATA;
        case (word_idx)
            crossing_irq_pkg::EDGE_SEL_IDX:
                nxt_readdata[crossing_irq_pkg::ENABLE_W-1:0] = edge_sel_ff;
            crossing_irq_pkg::IRQ_STATUS_IDX:
                nxt_readdata[NUM_INPUTS-1:0] = status_ff;
            crossing_irq_pkg::IRQ_MASK_IDX:
                nxt_readdata[NUM_INPUTS-1:0] = mask_ff;
            crossing_irq_pkg::LEVEL_IDX:
                nxt_readdata[NUM_INPUTS-1:0] = level_ff;
            default:
                nxt_readdata = crossing_irq_pkg::UNMAPPED_DATA;
        endcase
    end

    // registered read data, valid while waitrequest is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            av_readdata <= crossing_irq_pkg::UNMAPPED_DATA;
        end else if (rd_launch) begin
            av_readdata <= nxt_readdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next edge selection value, only lanes 0 to 2 hold fields
    always_comb begin
        nxt_edge_sel = edge_sel_ff;
        if (wr_take && hit_edge_sel) begin
            for (int b = 0; b < EDGE_LANES; b++) begin
                if (av_req.byteenable[b]) begin
                    nxt_edge_sel[b*LANE_W +: LANE_W] =
                        av_req.writedata[b*LANE_W +: LANE_W];
                end
            end
        end
    end

    // edge selection register, every input off after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_sel_ff <= crossing_irq_pkg::EDGE_SEL_RST;
        end else begin
            edge_sel_ff <= nxt_edge_sel;
        end
    end

    // next mask value, a one blocks the input from the irq pin
    always_comb begin
        nxt_mask = mask_ff;
        if (wr_take && hit_mask) begin
            nxt_mask = av_req.writedata[NUM_INPUTS-1:0];
        end
    end

    // mask register, every input masked after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_ff <= crossing_irq_pkg::MASK_RST;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // previous comparator levels, the edge reference for every input
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_ff <= '0;
        end else begin
            level_ff <= above_threshold;
        end
    end

    // history valid flag, the first sample after reset is no crossing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_valid_ff <= 1'b0;
        end else begin
            level_valid_ff <= 1'b1;
        end
    end

    // per-input crossing qualification by its edge selection code
    for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_cross
        logic [crossing_irq_pkg::SEL_W-1:0] sel;
        logic                               rise;
        logic                               fall;
        assign sel  = edge_sel_ff[i*crossing_irq_pkg::SEL_W +:
                                  crossing_irq_pkg::SEL_W];
        assign rise = level_valid_ff & above_threshold[i] & ~level_ff[i];
        assign fall = level_valid_ff & ~above_threshold[i] & level_ff[i];
        always_comb begin
            case (sel)
                crossing_irq_pkg::SEL_NONE: crossing_hit[i] = 1'b0;
                crossing_irq_pkg::SEL_RISE: crossing_hit[i] = rise;
                crossing_irq_pkg::SEL_FALL: crossing_hit[i] = fall;
                crossing_irq_pkg::SEL_BOTH:
                    crossing_hit[i] = rise | fall;
                default: crossing_hit[i] = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status bits that software asks to clear in this cycle
    assign clear_bits = (wr_take && hit_status) ?
                        av_req.writedata[NUM_INPUTS-1:0] : '0;

    // sticky status, write one to clear, a new event wins over the clear
    always_comb begin
        nxt_status = (status_ff & ~clear_bits) | crossing_hit;
    end

    // status register, nothing pending after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= '0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // events that reach the pin
    assign pending = status_ff & ~mask_ff;

    // active-low level interrupt while any unmasked status bit is set
    always_comb begin
        nxt_irq_n = ~|pending;
    end

    // interrupt pin register, released in reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= nxt_irq_n;
        end
    end

endmodule

//--- pkg/crossing_irq_pkg.sv
// shared constants and types for the input crossing interrupt block
package crossing_irq_pkg;
    localparam int NUM_INPUTS     = 12;
    localparam int SEL_W          = 2;
    localparam int ENABLE_W       = 24;
    localparam int ADDR_W         = 8;
    localparam int DATA_W         = 32;
    // register word offsets, byte address is four times the index
    localparam logic [ADDR_W-1:0] EDGE_SEL_IDX    = 8'h25;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_IDX  = 8'h28;
    localparam logic [ADDR_W-1:0] IRQ_MASK_IDX    = 8'h29;
    localparam logic [ADDR_W-1:0] LEVEL_IDX       = 8'h2A;
    localparam logic [ENABLE_W-1:0] EDGE_SEL_RST  = 24'h000000;
    localparam logic [NUM_INPUTS-1:0] MASK_RST    = 12'hFFF;
    localparam logic [DATA_W-1:0] UNMAPPED_DATA   = 32'h00000000;
    // edge selection codes
    localparam logic [SEL_W-1:0] SEL_NONE    = 2'h0;
    localparam logic [SEL_W-1:0] SEL_RISE    = 2'h1;
    localparam logic [SEL_W-1:0] SEL_FALL    = 2'h2;
    localparam logic [SEL_W-1:0] SEL_BOTH    = 2'h3;

    // one avalon request as seen by the slave
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [3:0]        byteenable;
    } av_req_s;
endpackage

//--- dv/av_host.sv
// avalon master model standing in for the host controller
`timescale 1ns/100ps
module av_host (
    input  wire logic                 clk,
    input  wire logic                 av_waitrequest,
    input  wire logic [31:0]          av_readdata,
    output crossing_irq_pkg::av_req_s av_req
);
    initial av_req = '0;
    // one transfer, held until waitrequest is sampled low
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        av_req <= '{!w, w, a, d, 4'hF};
        do @(posedge clk); while (av_waitrequest !== 1'b0);
        q = av_readdata;
        av_req.read <= 1'b0;
        av_req.write <= 1'b0;
        av_req.writedata <= ~d; // released data never looks stale
    endtask
endmodule

//--- dv/crossing_irq_chk.sv
// port assertions for the crossing interrupt block
`timescale 1ns/100ps
module crossing_irq_chk #(parameter int NUM_INPUTS = 12) (
    input wire logic                      clk,
    input wire logic                      rst_n,
    input wire crossing_irq_pkg::av_req_s av_req,
    input wire logic [31:0]               av_readdata,
    input wire logic                      av_waitrequest,
    input wire logic [NUM_INPUTS-1:0]     above_threshold,
    input wire logic                      irq_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire req = av_req.read | av_req.write;
    wire rd_ok = av_req.read & !av_waitrequest;
    logic wr_seen_ff;
    // remembers any write since reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) wr_seen_ff <= 1'b0;
        else if (av_req.write) wr_seen_ff <= 1'b1;
    end
    a_wait_one: assert property (req && av_waitrequest |=> !av_waitrequest)
        else $error("wait not one cycle");
    a_wait_stand: assert property (!av_waitrequest |=> av_waitrequest)
        else $error("ready held too long");
    a_hi_zero: assert property (rd_ok && av_req.address == 8'h94
        |-> av_readdata[31:24] == 8'h00) else $error("upper bits set");
    a_unmap_zero: assert property (rd_ok && av_req.address == 8'hFC
        |-> av_readdata == 32'h00000000) else $error("unmapped not zero");
    a_off_quiet: assert property (!wr_seen_ff |-> irq_n)
        else $error("irq while all off");
    a_sel_reset: assert property (rd_ok && av_req.address == 8'h94
        && !wr_seen_ff |-> av_readdata == 32'h00000000)
        else $error("edge select not zero after reset");
    a_irq_cause: assert property ($fell(irq_n) |->
        $past(above_threshold, 2) != $past(above_threshold, 3)
        || $past(av_req.write) || $past(av_req.write, 2))
        else $error("irq without crossing");
    a_irq_release: assert property ($rose(irq_n) |->
        $past(av_req.write) || $past(av_req.write, 2))
        else $error("irq dropped by itself");
    c_irq: cover property ($fell(irq_n));
    c_read: cover property (rd_ok);
    c_write: cover property (av_req.write && !av_waitrequest);
endmodule
bind input_crossing_irq_enable crossing_irq_chk #(.NUM_INPUTS(NUM_INPUTS)) chk_i (
    .clk(clk), .rst_n(rst_n), .av_req(av_req), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .above_threshold(above_threshold),
    .irq_n(irq_n));

//--- dv/tb_top.sv
// self-checking bench for the crossing interrupt block
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, wreq, irq_n;
    logic [11:0] lvl = 12'h000;
    logic [31:0] rdata, q;
    crossing_irq_pkg::av_req_s req;
    int n_fail = 0, cmp_count = 0, n;
    // rows: code, level before, level after, irq expected
    logic [4:0] rows [8] = '{5'h02, 5'h04, 5'h0B, 5'h0C,
                             5'h12, 5'h15, 5'h1B, 5'h1D};
    always #10 clk = ~clk;
    input_crossing_irq_enable input_crossing_irq_enable_i (.clk(clk),
        .rst_n(rst_n), .av_req(req), .av_readdata(rdata),
        .av_waitrequest(wreq), .above_threshold(lvl), .irq_n(irq_n));
    av_host av_host_i (.clk(clk), .av_waitrequest(wreq),
        .av_readdata(rdata), .av_req(req));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // waits for the crossing to reach the pin
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    initial begin
        #200000;
        n_fail++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // one input per row, each edge code against both crossings
        foreach (rows[i]) begin
            n = 11 - i;
            @(posedge clk);
            lvl[n] <= rows[i][2];
            av_host_i.xfer(1, 8'h94, 32'(rows[i][4:3]) << (2 * n), q);
            av_host_i.xfer(1, 8'hA4, ~(32'h1 << n) & 32'hFFF, q);
            av_host_i.xfer(1, 8'hA0, 32'hFFF, q);
            lvl[n] <= rows[i][1];
            settle();
            chk(irq_n, !rows[i][0]);
            av_host_i.xfer(0, 8'hA0, 0, q);
            chk(q, 32'(rows[i][0]) << n);
            av_host_i.xfer(1, 8'hA0, 32'hFFF, q);
            $display("row %0d done", i);
        end
        // reset mid-run, then register values and field layout
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        av_host_i.xfer(0, 8'h94, 0, q);
        chk(q, 32'h0);
        av_host_i.xfer(0, 8'hA4, 0, q);
        chk(q, 32'hFFF);
        av_host_i.xfer(1, 8'h94, 32'hFFFFFFFF, q);
        av_host_i.xfer(0, 8'h94, 0, q);
        chk(q, 32'h00FFFFFF);
        av_host_i.xfer(0, 8'hFC, 0, q);
        chk(q, 32'h0);
        $display("register test done");
        // all inputs cross while masked, then unmask and clear
        lvl <= ~lvl;
        settle();
        chk(irq_n, 1'b1);
        av_host_i.xfer(0, 8'hA8, 0, q);
        chk(q, 32'(lvl));
        av_host_i.xfer(0, 8'hA0, 0, q);
        chk(q, 32'hFFF);
        av_host_i.xfer(1, 8'hA4, 32'h0, q);
        settle();
        chk(irq_n, 1'b0);
        av_host_i.xfer(1, 8'hA0, 32'hFFF, q);
        settle();
        chk(irq_n, 1'b1);
        $display("mask test done");
        final_report();
    end
endmodule
